// *** verilog/bfpm_top.sv ***
// Breaker-not-open and fuel level protection monitor.
// Assumes configuration, mode and commands are synchronous to sys_clk.
`timescale 1ns/10ps
module bfpm_top
  import bfpm_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DFLT
)
(
  input  wire logic               sys_clk,
  input  wire logic               reset_n,
  input  wire logic               ce,
  input  wire bfpm_mode_t         mode,
  input  wire logic               engine_running,
  input  wire logic               mains_open_cmd,
  input  wire logic               gen_open_cmd,
  input  wire logic               mains_steady_close_output,
  input  wire logic               generator_steady_close_output,
  input  wire logic [N_DI-1:0]    di_level,
  input  wire logic [FUNC_W-1:0]  di_function [N_DI],
  input  wire logic [DELAY_W-1:0] di_delay [N_DI],
  input  wire logic               fuel_analog_cfg,
  input  wire logic               fuel_sensor_connected,
  input  wire logic [PCT_W-1:0]   fuel_level_pct,
  input  wire logic [PCT_W-1:0]   min_fuel_thresh,
  input  wire logic [DELAY_W-1:0] min_fuel_delay,
  input  wire logic [PCT_W-1:0]   low_fuel_thresh,
  input  wire logic [DELAY_W-1:0] low_fuel_delay,
  input  wire logic [PCT_W-1:0]   high_fuel_thresh,
  input  wire logic [DELAY_W-1:0] high_fuel_delay,
  input  wire logic               fault_clear,
  output logic                    mains_fault_deact,
  output logic                    mains_fault_warn,
  output logic                    gen_fault_block,
  output logic                    gen_fault_warn,
  output logic                    min_fuel_alarm,
  output logic                    low_fuel_warn,
  output logic                    high_fuel_warn
);

  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

  logic [TICK_W-1:0] tick_count;
  logic              tick;
  logic              eval;
  logic              unattended_any;
  logic              auto_mode;
  logic              analog_ok;

  logic [N_DI-1:0] is_mains;
  logic [N_DI-1:0] is_gen;
  logic [N_DI-1:0] is_min;
  logic [N_DI-1:0] is_low;
  logic [N_DI-1:0] is_high;
  logic [N_DI-1:0] di_cond;
  logic [N_DI-1:0] di_expired;

  logic mains_expire;
  logic gen_expire;
  logic mains_closed;
  logic gen_closed;
  logic mains_fault;
  logic gen_fault;
  logic min_analog_exp;
  logic low_analog_exp;
  logic high_analog_exp;
  logic min_fault;
  logic low_fault;
  logic high_fault;

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      tick_count <= '0;
      tick       <= 1'b0;
    end else if (ce) begin
      tick       <= tick_count == TICK_LAST;
      tick_count <= tick_count == TICK_LAST ? '0 : tick_count + 1'b1;
    end
  end

  assign eval = mode inside {BFPM_MODE_MANUAL, BFPM_MODE_AUTO,
                             BFPM_MODE_TEST, BFPM_MODE_REMOTE_START};
  assign unattended_any = eval && mode != BFPM_MODE_MANUAL;
  assign auto_mode = mode == BFPM_MODE_AUTO;
  assign analog_ok = eval && (fuel_analog_cfg || fuel_sensor_connected);

  // Each input runs its own timer on the condition of its function.
  for (genvar i = 0; i < N_DI; i++) begin : g_di
    assign is_mains[i] = di_function[i] == MAINS_BREAKER_STATUS_FUNCTION
                         && di_delay[i] != '0;
    assign is_gen[i]   = di_function[i] == GENERATOR_BREAKER_STATUS_FUNCTION
                         && di_delay[i] != '0;
    assign is_min[i]   = di_function[i] == MIN_FUEL_CONTACT_FUNCTION;
    assign is_low[i]   = di_function[i] == LOW_FUEL_CONTACT_FUNCTION;
    assign is_high[i]  = di_function[i] == HIGH_FUEL_CONTACT_FUNCTION;
    assign di_cond[i]  = eval && di_level[i] &&
                         ((is_mains[i] && mains_open_cmd) ||
                          (is_gen[i] && gen_open_cmd) ||
                          is_min[i] || is_low[i] || is_high[i]);

    bfpm_persist u_persist (
      .sys_clk (sys_clk),
      .reset_n (reset_n),
      .ce      (ce),
      .tick    (tick),
      .cond    (di_cond[i]),
      .delay   (di_delay[i]),
      .expired (di_expired[i])
    );
  end

  assign mains_expire = |(di_expired & is_mains);
  assign gen_expire   = |(di_expired & is_gen);
  assign mains_closed = |(di_level & is_mains);
  assign gen_closed   = |(di_level & is_gen);

  bfpm_retry u_mains_retry (
    .sys_clk    (sys_clk),
    .reset_n    (reset_n),
    .ce         (ce),
    .expire     (mains_expire),
    .unattended (auto_mode),
    .success    (mains_open_cmd && !mains_closed),
    .clear      (fault_clear || !eval),
    .fault      (mains_fault)
  );

  bfpm_retry u_gen_retry (
    .sys_clk    (sys_clk),
    .reset_n    (reset_n),
    .ce         (ce),
    .expire     (gen_expire),
    .unattended (auto_mode),
    .success    (gen_open_cmd && !gen_closed),
    .clear      (fault_clear || !eval),
    .fault      (gen_fault)
  );

  bfpm_persist u_min_analog (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .ce      (ce),
    .tick    (tick),
    .cond    (analog_ok && fuel_level_pct <= min_fuel_thresh),
    .delay   (min_fuel_delay),
    .expired (min_analog_exp)
  );

  bfpm_persist u_low_analog (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .ce      (ce),
    .tick    (tick),
    .cond    (analog_ok && fuel_level_pct <= low_fuel_thresh),
    .delay   (low_fuel_delay),
    .expired (low_analog_exp)
  );

  bfpm_persist u_high_analog (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .ce      (ce),
    .tick    (tick),
    .cond    (analog_ok && fuel_level_pct >= high_fuel_thresh),
    .delay   (high_fuel_delay),
    .expired (high_analog_exp)
  );

  // Fuel faults latch until cleared; a new expiry wins over the clear.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      min_fault  <= 1'b0;
      low_fault  <= 1'b0;
      high_fault <= 1'b0;
    end else if (ce) begin
      if (|(di_expired & is_min) || min_analog_exp) begin
        min_fault <= 1'b1;
      end else if (fault_clear || !eval) begin
        min_fault <= 1'b0;
      end
      if (|(di_expired & is_low) || low_analog_exp) begin
        low_fault <= 1'b1;
      end else if (fault_clear || !eval) begin
        low_fault <= 1'b0;
      end
      if (|(di_expired & is_high) || high_analog_exp) begin
        high_fault <= 1'b1;
      end else if (fault_clear || !eval) begin
        high_fault <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      mains_fault_deact <= 1'b0;
      mains_fault_warn  <= 1'b0;
    end else if (ce) begin
      mains_fault_deact <= mains_fault && unattended_any &&
                           mains_steady_close_output;
      mains_fault_warn  <= mains_fault && !(unattended_any &&
                           mains_steady_close_output);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      gen_fault_block <= 1'b0;
      gen_fault_warn  <= 1'b0;
    end else if (ce) begin
      gen_fault_block <= gen_fault && auto_mode && engine_running &&
                         generator_steady_close_output;
      gen_fault_warn  <= gen_fault && !(auto_mode && engine_running &&
                         generator_steady_close_output);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      min_fuel_alarm <= 1'b0;
      low_fuel_warn  <= 1'b0;
      high_fuel_warn <= 1'b0;
    end else if (ce) begin
      min_fuel_alarm <= min_fault;
      low_fuel_warn  <= low_fault;
      high_fuel_warn <= high_fault;
    end
  end

  sequence s_mains_rise;
    (ce && !mains_fault) ##1 mains_fault;
  endsequence

  sequence s_idle_mode;
    ce && !eval;
  endsequence

  AST_MAINS_ARM: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (ce && is_mains == '0 && !mains_fault) |=> !mains_fault)
    else $error("mains fault without an armed input");

  AST_GEN_ARM: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (ce && is_gen == '0 && !gen_fault) |=> !gen_fault)
    else $error("generator fault without an armed input");

  AST_MAINS_COND: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (ce && !mains_open_cmd) |=> !mains_expire)
    else $error("mains timer ran without open command");

  AST_GEN_COND: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (ce && !gen_open_cmd) |=> !gen_expire)
    else $error("generator timer ran without open command");

  AST_MAINS_DEACT: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (ce && mains_fault && unattended_any && mains_steady_close_output)
      |=> mains_fault_deact && !mains_fault_warn)
    else $error("mains fault not a deactivation");

  AST_MAINS_WARN: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (ce && mains_fault && !unattended_any)
      |=> mains_fault_warn && !mains_fault_deact)
    else $error("attended mains fault not a warning");

  AST_GEN_BLOCK: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (ce && gen_fault && !auto_mode) |=> gen_fault_warn && !gen_fault_block)
    else $error("generator fault blocked outside auto");

  AST_GEN_BLOCK_ON: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (ce && gen_fault && auto_mode && engine_running &&
     generator_steady_close_output) |=> gen_fault_block && !gen_fault_warn)
    else $error("generator fault not a block");

  AST_MIN_ALARM: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (ce && min_analog_exp) ##1 ce |=> min_fuel_alarm)
    else $error("minimum level alarm missing");

  AST_LOW_WARN: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (ce && low_analog_exp) ##1 ce |=> low_fuel_warn)
    else $error("low level warning missing");

  AST_ANALOG_GATE: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (ce && !fuel_analog_cfg && !fuel_sensor_connected)
      |=> !low_analog_exp && !high_analog_exp)
    else $error("analogue check without sensor");

  AST_MODE_GATE: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    s_idle_mode ##1 s_idle_mode |=> !min_fault && !mains_fault)
    else $error("fault held outside evaluating modes");

  AST_MAINS_STUCK_TIMER: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    s_mains_rise |-> $past(mains_open_cmd && mains_closed && eval, 2))
    else $error("mains fault without a stuck closed breaker");

endmodule : bfpm_top

// *** verilog/bfpm_pkg.sv ***
// Shared constants and types of the breaker and fuel protection monitor.
// Assumes a single 10 MHz clock and a synchronous active-low reset.
// Function
// - Mains check armed by assigned, delayed input.
// - Mains fault: commanded open, stays closed.
// - Auto: fault after three failed open attempts, else after one.
// - Mains: deactivation when unattended with steady close.
// - Generator check armed by assigned, delayed input.
// - Generator fault: commanded open, stays closed.
// - Generator: block when auto, running, steady close.
// - Minimum fuel contact raises alarm after delay.
// - Analogue level at/below minimum raises alarm.
// - Low fuel contact raises warning after delay.
// - Analogue level at/below low raises warning.
// - High fuel contact raises warning after delay.
// - Analogue level at/above high raises warning.
// - Analogue checks need configuration or connected sensor.
// - Checks run in manual, auto, test, remote.
package bfpm_pkg;

  localparam int N_DI = 4;
  localparam int FUNC_W = 16;
  localparam int DELAY_W = 16;
  localparam int PCT_W = 7;

  // Input function codes, as numbered in the configuration table.
  localparam logic [FUNC_W-1:0] GENERATOR_BREAKER_STATUS_FUNCTION = 16'h0bb9;
  localparam logic [FUNC_W-1:0] MAINS_BREAKER_STATUS_FUNCTION     = 16'h0bba;
  localparam logic [FUNC_W-1:0] MIN_FUEL_CONTACT_FUNCTION         = 16'h1073;
  localparam logic [FUNC_W-1:0] LOW_FUEL_CONTACT_FUNCTION         = 16'h1074;
  localparam logic [FUNC_W-1:0] HIGH_FUEL_CONTACT_FUNCTION        = 16'h1075;

  localparam logic [1:0] OPEN_ATTEMPTS = 2'h3;

  // Delays count in ticks of 100 ms.
  localparam longint TICK_PERIOD_NS = 100_000_000;
  localparam longint CLK_PERIOD_NS = 100;
  localparam int TICK_CYCLES_DFLT = int'(TICK_PERIOD_NS / CLK_PERIOD_NS);
  localparam int TICK_W = 24;

  typedef enum logic [2:0] {
    BFPM_MODE_OFF,
    BFPM_MODE_MANUAL,
    BFPM_MODE_AUTO,
    BFPM_MODE_TEST,
    BFPM_MODE_REMOTE_START
  } bfpm_mode_t;

endpackage : bfpm_pkg

// *** verilog/bfpm_persist.sv ***
// Persistence timer: reports a condition held without a break for a delay.
// Assumes a one-cycle tick strobe; delay is in ticks, zero disables.
`timescale 1ns/10ps
module bfpm_persist
  import bfpm_pkg::*;
(
  input  wire logic               sys_clk,
  input  wire logic               reset_n,
  input  wire logic               ce,
  input  wire logic               tick,
  input  wire logic               cond,
  input  wire logic [DELAY_W-1:0] delay,
  output logic                    expired
);

  logic [DELAY_W-1:0] count;

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      count <= '0;
    end else if (ce) begin
      if (!cond) begin
        count <= '0;
      end else if (tick && count < delay) begin
        count <= count + 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      expired <= 1'b0;
    end else if (ce) begin
      expired <= cond && delay != '0 && count >= delay;
    end
  end

  AST_PERSIST_RESTART: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (ce && !cond) |=> (count == '0 && !expired))
    else $error("timer did not restart after condition lapsed");

  AST_PERSIST_ZERO_OFF: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (ce && delay == '0) |=> !expired)
    else $error("zero delay still expired");

endmodule : bfpm_persist

// *** verilog/bfpm_retry.sv ***
// Failed-open attempt counter and fault latch for one breaker.
// Assumes expire is a level that rises once per failed open attempt.
`timescale 1ns/10ps
module bfpm_retry
  import bfpm_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic reset_n,
  input  wire logic ce,
  input  wire logic expire,
  input  wire logic unattended,
  input  wire logic success,
  input  wire logic clear,
  output logic      fault
);

  logic       expire_d;
  logic       attempt;
  logic [1:0] attempts;
  logic [1:0] next_attempts;

  assign attempt = expire && !expire_d;
  assign next_attempts = attempts + 2'h1;

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      expire_d <= 1'b0;
    end else if (ce) begin
      expire_d <= expire;
    end
  end

  // A breaker that opens ends the series of failed attempts.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      attempts <= '0;
    end else if (ce) begin
      if (attempt && unattended && next_attempts != OPEN_ATTEMPTS) begin
        attempts <= next_attempts;
      end else if (attempt || success || clear) begin
        attempts <= '0;
      end
    end
  end

  // A new failure wins over a clear in the same cycle.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      fault <= 1'b0;
    end else if (ce) begin
      if (attempt && (!unattended || next_attempts == OPEN_ATTEMPTS)) begin
        fault <= 1'b1;
      end else if (clear) begin
        fault <= 1'b0;
      end
    end
  end

  sequence s_two_failed;
    attempt && unattended && attempts == 2'h2;
  endsequence

  AST_RETRY_THIRD: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (ce and s_two_failed) |=> fault)
    else $error("third failed attempt did not raise fault");

  AST_RETRY_EARLY: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (ce && attempt && unattended && attempts == 2'h0 && !fault)
      |=> !fault)
    else $error("fault raised on first unattended attempt");

endmodule : bfpm_retry

// *** bench/bfpm_field.sv ***
// Field model: breaker auxiliary contacts, fuel floats and level sensor.
// Assumes its controls change at the falling edge of sys_clk.
`timescale 1ns/10ps
module bfpm_field
  import bfpm_pkg::*;
(
  input  wire logic             sys_clk,
  input  wire logic             mains_open_cmd,
  input  wire logic             gen_open_cmd,
  input  wire logic             stuck,
  input  wire logic [1:0]       float_active,
  input  wire logic [3:0]       travel,
  input  wire logic             sensor_present,
  input  wire logic [PCT_W-1:0] level_set,
  output logic [N_DI-1:0]       di_level,
  output logic [PCT_W-1:0]      fuel_level_pct
);
  logic [3:0]       mains_run = 4'h0;
  logic [3:0]       gen_run   = 4'h0;
  logic [PCT_W-1:0] noise     = 7'h00;

  // A breaker leaves its closed contact only after travelling.
  // Commands are held for less than 16 cycles, so the counters never wrap.
  always_ff @(posedge sys_clk) begin
    mains_run <= (mains_open_cmd && !stuck) ? mains_run + 4'h1 : 4'h0;
    gen_run   <= (gen_open_cmd && !stuck) ? gen_run + 4'h1 : 4'h0;
  end

  // A disconnected sensor input floats and reads a changing value.
  always_ff @(posedge sys_clk) begin
    noise <= noise + 7'h25;
  end

  assign di_level = {float_active, gen_run <= travel, mains_run <= travel};
  assign fuel_level_pct = sensor_present ? level_set : noise;
endmodule : bfpm_field

// *** bench/bfpm_top_tb.sv ***
// Self-checking bench of the breaker and fuel protection monitor.
// Assumes the field model bfpm_field and a tick of 4 clock cycles.
`timescale 1ns/10ps
module bfpm_top_tb;
  import bfpm_pkg::*;
  localparam int TK = 4;
  localparam logic [6:0] O_MD = 7'h01, O_MW = 7'h02, O_GB = 7'h04;
  localparam logic [6:0] O_GW = 7'h08, O_MIN = 7'h10, O_LOW = 7'h20;
  localparam logic [6:0] O_HI = 7'h40;
  logic               sys_clk = 1'b0;
  logic               reset_n = 1'b0;
  bfpm_mode_t         mode = BFPM_MODE_OFF;
  logic               running = 1'b0;
  logic               m_cmd = 1'b0;
  logic               g_cmd = 1'b0;
  logic               m_steady = 1'b0;
  logic               g_steady = 1'b0;
  logic               stuck = 1'b1;
  logic [1:0]         float_active = 2'h0;
  logic [3:0]         travel = 4'h3;
  logic               present = 1'b0;
  logic               fuel_cfg = 1'b0;
  logic [PCT_W-1:0]   level_set = 7'h32;
  logic [PCT_W-1:0]   th [3] = '{7'h0a, 7'h14, 7'h50};
  logic [DELAY_W-1:0] fd [3] = '{16'h0001, 16'h0001, 16'h0001};
  logic               fault_clear = 1'b0;
  logic               ce = 1'b1;
  logic [FUNC_W-1:0]  di_function [N_DI];
  logic [DELAY_W-1:0] di_delay [N_DI];
  logic [N_DI-1:0]    di_level;
  logic [PCT_W-1:0]   fuel_pct;
  wire  [6:0]         outs;
  int                 num_errors = 0;
  int                 checked = 0;
  int                 cycles = 0;

  bfpm_field FIELD (.sys_clk(sys_clk), .mains_open_cmd(m_cmd),
    .gen_open_cmd(g_cmd), .stuck(stuck), .float_active(float_active),
    .travel(travel), .sensor_present(present), .level_set(level_set),
    .di_level(di_level), .fuel_level_pct(fuel_pct));

  bfpm_top #(.TICK_CYCLES(TK)) DUT (.sys_clk(sys_clk), .reset_n(reset_n),
    .ce(ce), .mode(mode), .engine_running(running),
    .mains_open_cmd(m_cmd), .gen_open_cmd(g_cmd),
    .mains_steady_close_output(m_steady),
    .generator_steady_close_output(g_steady), .di_level(di_level),
    .di_function(di_function), .di_delay(di_delay),
    .fuel_analog_cfg(fuel_cfg), .fuel_sensor_connected(present),
    .fuel_level_pct(fuel_pct), .min_fuel_thresh(th[0]),
    .min_fuel_delay(fd[0]), .low_fuel_thresh(th[1]),
    .low_fuel_delay(fd[1]), .high_fuel_thresh(th[2]),
    .high_fuel_delay(fd[2]), .fault_clear(fault_clear),
    .mains_fault_deact(outs[0]), .mains_fault_warn(outs[1]),
    .gen_fault_block(outs[2]), .gen_fault_warn(outs[3]),
    .min_fuel_alarm(outs[4]), .low_fuel_warn(outs[5]),
    .high_fuel_warn(outs[6]));

  initial begin
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic results;
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : results

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      $display("mismatch run_length expected end seen timeout");
      results();
    end
  end

  task automatic chk(input string what, input logic [6:0] exp,
                     input logic [6:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : cyc

  // A quiet expectation waits the full bound so a late fault is seen.
  task automatic await(input string what, input logic [6:0] exp,
                       input int maxc);
    if (exp === 7'h00) cyc(maxc);
    for (int i = 0; i < maxc && outs !== exp; i++) cyc(1);
    chk(what, exp, outs);
  endtask : await

  task automatic clear_all;
    m_cmd = 1'b0;
    g_cmd = 1'b0;
    float_active = 2'h0;
    mode = BFPM_MODE_OFF;
    cyc(3);
  endtask : clear_all

  task automatic attempt(input logic gen, input logic ok,
                         input logic [6:0] exp);
    stuck = !ok;
    if (gen) g_cmd = 1'b1;
    else m_cmd = 1'b1;
    await("breaker", exp, 2 * TK + 6);
    m_cmd = 1'b0;
    g_cmd = 1'b0;
    cyc(3);
  endtask : attempt

  function automatic logic [6:0] fuel_exp(input logic en,
                                          input logic [PCT_W-1:0] lv);
    fuel_exp = 7'h00;
    if (en && fd[0] != 0 && lv <= th[0]) fuel_exp |= O_MIN;
    if (en && fd[1] != 0 && lv <= th[1]) fuel_exp |= O_LOW;
    if (en && fd[2] != 0 && lv >= th[2]) fuel_exp |= O_HI;
  endfunction : fuel_exp

  initial begin
    logic [FUNC_W-1:0] fn [3];
    logic [6:0]        fo [3];
    logic              en;
    fn = '{MIN_FUEL_CONTACT_FUNCTION, LOW_FUEL_CONTACT_FUNCTION,
           HIGH_FUEL_CONTACT_FUNCTION};
    fo = '{O_MIN, O_LOW, O_HI};
    di_function = '{MAINS_BREAKER_STATUS_FUNCTION,
      GENERATOR_BREAKER_STATUS_FUNCTION, 16'h0000, 16'h0000};
    di_delay = '{16'h0002, 16'h0002, 16'h0003, 16'h0000};
    void'($urandom(32'h5d77_fa5d));
    cyc(3);
    chk("reset", 7'h00, outs);
    cyc(2);
    reset_n = 1'b1;
    mode = BFPM_MODE_MANUAL;
    m_steady = 1'b1;
    attempt(1'b0, 1'b0, O_MW);
    ce = 1'b0;
    fault_clear = 1'b1;
    cyc(3);
    chk("frozen", O_MW, outs);
    ce = 1'b1;
    cyc(1);
    fault_clear = 1'b0;
    await("clear", 7'h00, 3);
    attempt(1'b0, 1'b1, 7'h00);
    mode = BFPM_MODE_AUTO;
    attempt(1'b0, 1'b0, 7'h00);
    attempt(1'b0, 1'b0, 7'h00);
    attempt(1'b0, 1'b1, 7'h00);
    attempt(1'b0, 1'b0, 7'h00);
    attempt(1'b0, 1'b0, 7'h00);
    attempt(1'b0, 1'b0, O_MD);
    clear_all();
    mode = BFPM_MODE_TEST;
    attempt(1'b0, 1'b0, O_MD);
    m_steady = 1'b0;
    await("severity", O_MW, 3);
    clear_all();
    mode = BFPM_MODE_REMOTE_START;
    di_delay[0] = 16'h0000;
    attempt(1'b0, 1'b0, 7'h00);
    di_delay[0] = 16'h0002;
    di_function[0] = 16'h0000;
    attempt(1'b0, 1'b0, 7'h00);
    di_function[0] = MAINS_BREAKER_STATUS_FUNCTION;
    mode = BFPM_MODE_MANUAL;
    attempt(1'b1, 1'b0, O_GW);
    clear_all();
    mode = BFPM_MODE_AUTO;
    running = 1'b1;
    g_steady = 1'b1;
    repeat (2) attempt(1'b1, 1'b0, 7'h00);
    attempt(1'b1, 1'b0, O_GB);
    running = 1'b0;
    await("severity", O_GW, 3);
    clear_all();
    di_delay[1] = 16'h0000;
    mode = BFPM_MODE_MANUAL;
    attempt(1'b1, 1'b0, 7'h00);
    for (int k = 0; k < 3; k++) begin
      di_function[2] = fn[k];
      di_function[3] = fn[k];
      mode = bfpm_mode_t'($urandom_range(4, 1));
      float_active = 2'h3;
      cyc(7);
      float_active = 2'h2;
      cyc(2);
      float_active = 2'h3;
      await("float_early", 7'h00, 9);
      await("float", fo[k], 3 * TK + 6);
      clear_all();
    end
    di_function[2] = 16'h0000;
    for (int t = 0; t < 14; t++) begin
      present = ($urandom_range(2) != 0);
      fuel_cfg = present && ($urandom_range(1) != 0);
      for (int j = 0; j < 3; j++) begin
        th[j] = 7'($urandom_range(100));
        fd[j] = 16'($urandom_range(2));
      end
      level_set = 7'($urandom_range(100));
      if (t < 3) level_set = th[t];
      mode = bfpm_mode_t'($urandom_range(4, t < 12 ? 1 : 0));
      en = (present || fuel_cfg) && mode != BFPM_MODE_OFF;
      await("fuel", fuel_exp(en, level_set), 2 * TK + 6);
      clear_all();
    end
    // A configured but unplugged sensor reads noise, always at or under full scale.
    present = 1'b0;
    fuel_cfg = 1'b1;
    th[0] = 7'h7f;
    fd = '{16'h0001, 16'h0000, 16'h0000};
    mode = BFPM_MODE_MANUAL;
    await("fuel_cfg", O_MIN, 2 * TK + 6);
    results();
  end
endmodule : bfpm_top_tb
